// ---- sacc_cfg.svh ----
`ifndef SACC_CFG_SVH
`define SACC_CFG_SVH
`define SACC_CH_W         5
`define SACC_CH_OFF       5'h1f
`define SACC_CH_TEMP      5'h1a
`define SACC_CH_BGAP      5'h1b
`define SACC_CH_RSVD_HI   5'h1c
`define SACC_CH_VREFH     5'h1d
`define SACC_CH_VREFL     5'h1e
`define SACC_CH_RSVD_LO   5'h16
`define SACC_CH_RSVD_TOP  5'h19
`define SACC_CH_NUM       28
`define SACC_RES_W        10
`define SACC_RTI_W        16
`define SACC_LPO_HZ       1000
`define SACC_CLK_HZ       50000000
`define SACC_LPO_CYC      (`SACC_CLK_HZ / `SACC_LPO_HZ)
`define SACC_SAMPLE_SHORT 4'h2
`define SACC_SAMPLE_LONG  4'h8
`define SACC_PIN_REGS     2
`endif

// ---- sacc_pkg.sv ----
package sacc_pkg;
	typedef enum logic [1:0] {SRC_BUS, SRC_BUS_HALF, SRC_LOCAL, SRC_ALT} sacc_src_t;
	typedef enum logic [1:0] {IN_PIN, IN_VREFL, IN_INTERNAL, IN_RESERVED} sacc_kind_t;
	typedef struct packed {
		logic [4:0] channelSelect;
		logic       completeIntEnable;
		logic       continuous;
		logic       hwTrigEnable;
		logic       compareEnable;
		logic       compareGreater;
		logic       mode8;
		logic       longSample;
		logic       lowPower;
		sacc_src_t  clkSource;
		logic [1:0] clockDivideSelect;
	} sacc_ctrl_t;
	typedef struct packed {
		logic       sampleHold;
		logic       compHigh;
		logic [9:0] dacCode;
		logic [4:0] muxSelect;
		logic       powerUp;
	} sacc_analog_t;
endpackage

// ---- sacc_clkdiv.sv ----
`timescale 1ns/1ns
`include "sacc_cfg.svh"
// Divides the selected source tick stream into conversion clock ticks.
module sacc_clkdiv
	import sacc_pkg::*;
(
	input  wire logic       core_clk,  // system clock
	input  wire logic       sys_rst,   // sync reset
	input  wire logic       clkEn,     // global clock enable
	input  wire logic       clear,     // restart divider
	input  wire logic       srcTick,   // selected source tick
	input  wire logic [1:0] divSel,    // divide by 1,2,4,8
	output logic            convTick   // conversion clock tick
);
	logic [2:0] cnt_r;
	logic [2:0] lim;

	assign lim      = 3'((4'h1 << divSel) - 4'h1);
	assign convTick = srcTick && (cnt_r == lim);

	always_ff @(posedge core_clk)
	begin
		if (sys_rst || (clkEn && clear))
			cnt_r <= 3'h0;
		else if (clkEn && srcTick)
			cnt_r <= (cnt_r == lim) ? 3'h0 : 3'(cnt_r + 3'h1);
	end
endmodule

// ---- sacc_ctrl.sv ----
`timescale 1ns/1ns
`include "sacc_cfg.svh"
// Function
// - Five-bit channel select addresses channels 0..27 plus internal and disable codes.
// - Only channels 0-3 and 8-11 are real external inputs.
// - Unimplemented channel codes route the converter input to the low reference.
// - Reserved codes convert to an undefined value.
// - All-ones select powers the converter down and stops continuous conversion.
// - Codes 26,27,29,30 route temperature, bandgap, high and low reference.
// - Each pin-shared channel has its own analog pin enable bit.
// - Conversion clock source picks bus, half bus, local async or alternate clock.
// - Selected source is divided by the divide select; software keeps range.
// - With hardware trigger enabled, periodic counter overflow starts a conversion.
// - Periodic counter runs freely, rate selectable, clocked by reference or 1 kHz.
// - Results are right-justified in 10-bit or 8-bit format.
// - Single or continuous conversion; single returns to idle by itself.
// - Optional compare flags less-than, or greater-or-equal, against a value.
// - Completion sets a flag and, when enabled, raises an interrupt.
// - Flag clears on control write or low result read; compare gates its setting.
// - Control write aborts a conversion and restarts unless select is all ones or hardware trigger is enabled.
// - Two analog pin enable registers cover the pin-shared channels.
// - Linear successive approximation resolves ten bits, one per step.
// - Sample time and speed versus power are configurable.
module sacc_ctrl
	import sacc_pkg::*;
#(
	parameter int RTI_W = `SACC_RTI_W,
	parameter int LPO_CYC = `SACC_LPO_CYC
)
(
	input  wire logic         core_clk,          // 50 MHz system clock
	input  wire logic         sys_rst,           // sync reset, active high
	input  wire logic         clkEn,             // freezes all state when low
	input  wire sacc_ctrl_t   ctrlIn,            // control value written
	input  wire logic         ctrlWrite,         // control register write strobe
	input  wire logic [9:0]   compareValue,      // compare value
	input  wire logic         resultLowRead,     // low result byte read strobe
	input  wire logic [15:0]  pinEnableIn,       // two pin enable registers
	input  wire logic         pinEnableWrite,    // pin enable write strobe
	input  wire logic         localAsyncTick,    // local async clock edge
	input  wire logic         altClockTick,      // alternate clock edge
	input  wire logic         refClockTick,      // external reference clock edge
	input  wire logic         rtiUseRef,         // periodic counter on reference clock
	input  wire logic [3:0]   periodicRateSelect,// overflow rate select
	input  wire logic         comparatorHigh,    // analog comparator: input at or above DAC
	output sacc_analog_t      analogOut,         // analog front end control
	output logic [9:0]        result,            // formatted result
	output logic              conversionComplete,// complete flag
	output logic              completeIrq,       // interrupt request
	output logic              busy,              // conversion in progress
	output logic [15:0]       pinEnable,         // analog pin enables
	output sacc_kind_t        inputKind          // decoded kind of selection
);
	typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} sacc_state_t;

	sacc_ctrl_t  ctrl_r;
	sacc_state_t state_r;
	logic [3:0]  sampleCnt_r;
	logic [3:0]  bitIdx_r;
	logic [9:0]  sar_r;
	logic [9:0]  result_r;
	logic        conversion_complete_flag_r;
	logic [15:0] pinEn_r;
	logic [RTI_W-1:0] rti_r;
	logic [31:0] lpoCnt_r;
	logic        trigPend_r;
	logic        halfTgl_r;
	logic        srcTick;
	logic        convTick;
	logic        lpoTick;
	logic        rtiTick;
	logic        rtiOvf;
	logic        startReq;
	logic        sarDone;
	logic [9:0]  finalCode;
	logic        cmpTrue;

	// ========================================================================
	// Channel decode
	// ========================================================================
	function automatic sacc_kind_t kindOf(input logic [4:0] ch);
		if (ch[4:3] == 2'b00 && !ch[2])
			return IN_PIN;
		if (ch[4:3] == 2'b01 && !ch[2])
			return IN_PIN;
		if ((ch >= `SACC_CH_RSVD_LO && ch <= `SACC_CH_RSVD_TOP) || ch == `SACC_CH_RSVD_HI)
			return IN_RESERVED;
		if (ch == `SACC_CH_TEMP || ch == `SACC_CH_BGAP || ch == `SACC_CH_VREFH)
			return IN_INTERNAL;
		return IN_VREFL;
	endfunction

	function automatic logic isOff(input logic [4:0] ch);
		return ch == `SACC_CH_OFF;
	endfunction

	assign inputKind = kindOf(ctrl_r.channelSelect);

	// ========================================================================
	// Registers written by software
	// ========================================================================
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			ctrl_r <= '{channelSelect: `SACC_CH_OFF, clkSource: SRC_BUS, default: '0};
		else if (clkEn && ctrlWrite)
			ctrl_r <= ctrlIn;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			pinEn_r <= 16'h0000;
		else if (clkEn && pinEnableWrite)
			pinEn_r <= pinEnableIn;
	end
	assign pinEnable = pinEn_r;

	// ========================================================================
	// Conversion clock
	// ========================================================================
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			halfTgl_r <= 1'b0;
		else if (clkEn)
			halfTgl_r <= ~halfTgl_r;
	end

	// Async ticks arrive already synchronised as single-cycle enables.
	always_comb
	begin
		case (ctrl_r.clkSource)
			SRC_BUS:      srcTick = 1'b1;
			SRC_BUS_HALF: srcTick = halfTgl_r;
			SRC_LOCAL:    srcTick = localAsyncTick;
			SRC_ALT:      srcTick = altClockTick;
			default:      srcTick = 1'b0;
		endcase
	end

	sacc_clkdiv u_div
	(
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.clkEn    (clkEn),
		.clear    (ctrlWrite),
		.srcTick  (srcTick),
		.divSel   (ctrl_r.clockDivideSelect),
		.convTick (convTick)
	);

	// ========================================================================
	// Periodic wake counter and hardware trigger
	// ========================================================================
	assign lpoTick = (lpoCnt_r == 32'(LPO_CYC - 1));
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			lpoCnt_r <= 32'h0;
		else if (clkEn)
			lpoCnt_r <= lpoTick ? 32'h0 : 32'(lpoCnt_r + 32'h1);
	end

	// Overflow when the count bits from zero up to the rate select are all ones.
	function automatic logic rtiAtTop(input logic [RTI_W-1:0] cnt, input logic [3:0] sel);
		logic [RTI_W-1:0] mask;
		mask = RTI_W'((RTI_W'(1) << (5'(sel) + 5'h1)) - RTI_W'(1));
		return (cnt & mask) == mask;
	endfunction

	assign rtiTick = rtiUseRef ? refClockTick : lpoTick;
	assign rtiOvf  = rtiTick && rtiAtTop(rti_r, periodicRateSelect);
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			rti_r <= '0;
		else if (clkEn && rtiTick)
			rti_r <= rtiAtTop(rti_r, periodicRateSelect) ? '0 : RTI_W'(rti_r + 1'b1);
	end

	// A trigger waits for the next conversion clock tick so none is lost.
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			trigPend_r <= 1'b0;
		else if (clkEn)
		begin
			// An overflow in the write cycle is kept for the newly written setting.
			if (ctrlWrite)
				trigPend_r <= rtiOvf && ctrlIn.hwTrigEnable && !isOff(ctrlIn.channelSelect);
			else if (rtiOvf && ctrl_r.hwTrigEnable && !isOff(ctrl_r.channelSelect))
				trigPend_r <= 1'b1;
			else if (state_r == ST_IDLE && convTick)
				trigPend_r <= 1'b0;
		end
	end

	// ========================================================================
	// Sequencer
	// ========================================================================
	assign startReq  = trigPend_r && convTick;
	assign sarDone   = (state_r == ST_CONVERT) && convTick && (bitIdx_r == 4'h0);
	assign finalCode = comparatorHigh ? sar_r : (sar_r & ~(10'h1 << bitIdx_r));
	assign cmpTrue   = ctrl_r.compareGreater ? (finalCode >= compareValue)
	                                         : (finalCode < compareValue);

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			state_r     <= ST_IDLE;
			sampleCnt_r <= 4'h0;
			bitIdx_r    <= 4'h0;
			sar_r       <= 10'h0;
		end
		else if (clkEn)
		begin
			if (ctrlWrite)
			begin
				// Abort, then restart in software mode unless the write disables.
				state_r     <= (!isOff(ctrlIn.channelSelect) && !ctrlIn.hwTrigEnable)
				               ? ST_SAMPLE : ST_IDLE;
				sampleCnt_r <= ctrlIn.longSample ? `SACC_SAMPLE_LONG : `SACC_SAMPLE_SHORT;
				bitIdx_r    <= 4'h9;
				sar_r       <= 10'h200;
			end
			else
			begin
				case (state_r)
					ST_IDLE:
					begin
						if (startReq)
						begin
							state_r     <= ST_SAMPLE;
							sampleCnt_r <= ctrl_r.longSample ? `SACC_SAMPLE_LONG : `SACC_SAMPLE_SHORT;
							bitIdx_r    <= 4'h9;
							sar_r       <= 10'h200;
						end
					end
					ST_SAMPLE:
					begin
						if (convTick)
						begin
							if (sampleCnt_r == 4'h1)
								state_r <= ST_CONVERT;
							sampleCnt_r <= 4'(sampleCnt_r - 4'h1);
						end
					end
					ST_CONVERT:
					begin
						if (convTick)
						begin
							if (bitIdx_r == 4'h0)
							begin
								// Continuous software mode loops; hardware mode waits.
								state_r <= (ctrl_r.continuous && !ctrl_r.hwTrigEnable)
								           ? ST_SAMPLE : ST_IDLE;
								sampleCnt_r <= ctrl_r.longSample ? `SACC_SAMPLE_LONG : `SACC_SAMPLE_SHORT;
								bitIdx_r    <= 4'h9;
								sar_r       <= 10'h200;
							end
							else
							begin
								sar_r    <= finalCode | (10'h1 << (bitIdx_r - 4'h1));
								bitIdx_r <= 4'(bitIdx_r - 4'h1);
							end
						end
					end
					default: state_r <= ST_IDLE;
				endcase
			end
		end
	end

	// ========================================================================
	// Result and completion flag
	// ========================================================================
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			result_r <= 10'h000;
		else if (clkEn && sarDone && !ctrlWrite && (!ctrl_r.compareEnable || cmpTrue))
			result_r <= ctrl_r.mode8 ? {2'b00, finalCode[9:2]} : finalCode;
	end
	assign result = result_r;

	// A completion in the same cycle as a low-byte read wins over the clear.
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			conversion_complete_flag_r <= 1'b0;
		else if (clkEn)
		begin
			if (ctrlWrite)
				conversion_complete_flag_r <= 1'b0;
			else if (sarDone && (!ctrl_r.compareEnable || cmpTrue))
				conversion_complete_flag_r <= 1'b1;
			else if (resultLowRead)
				conversion_complete_flag_r <= 1'b0;
		end
	end
	assign conversionComplete = conversion_complete_flag_r;
	assign completeIrq        = conversion_complete_flag_r && ctrl_r.completeIntEnable;
	assign busy               = (state_r != ST_IDLE);

	// ========================================================================
	// Analog front end
	// ========================================================================
	always_comb
	begin
		analogOut.powerUp    = busy && !isOff(ctrl_r.channelSelect);
		analogOut.muxSelect  = ctrl_r.channelSelect;
		analogOut.dacCode    = sar_r;
		analogOut.sampleHold = (state_r == ST_SAMPLE);
		analogOut.compHigh   = ctrl_r.lowPower;
	end

	// ========================================================================
	// Checks
	// ========================================================================
	chk_irq_follows_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
		completeIrq == (conversionComplete && ctrl_r.completeIntEnable))
		else $error("interrupt does not follow complete flag");

	chk_write_clears_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
		clkEn && ctrlWrite |=> !conversionComplete)
		else $error("control write left complete flag set");

	chk_off_stops: assert property (@(posedge core_clk) disable iff (sys_rst)
		clkEn && ctrlWrite && isOff(ctrlIn.channelSelect) |=> !busy ##1 !busy)
		else $error("disabled select still converting");

	chk_write_restarts: assert property (@(posedge core_clk) disable iff (sys_rst)
		clkEn && ctrlWrite && !isOff(ctrlIn.channelSelect) && !ctrlIn.hwTrigEnable
		|=> state_r == ST_SAMPLE)
		else $error("control write did not restart");

	chk_single_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
		clkEn && sarDone && !ctrlWrite && !ctrl_r.continuous |=> state_r == ST_IDLE)
		else $error("single conversion did not return to idle");

	chk_compare_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
		clkEn && !ctrlWrite && !resultLowRead && ctrl_r.compareEnable && !$past(conversionComplete)
		&& !conversionComplete ##1 conversionComplete |-> $past(cmpTrue && sarDone))
		else $error("flag set without true compare");

	chk_mode8_range: assert property (@(posedge core_clk) disable iff (sys_rst)
		$changed(result) && ctrl_r.mode8 |-> result[9:8] == 2'b00)
		else $error("8-bit result not right-justified");

	chk_trigger_start: assert property (@(posedge core_clk) disable iff (sys_rst)
		clkEn && state_r == ST_IDLE && startReq && !ctrlWrite |=> state_r == ST_SAMPLE)
		else $error("pending trigger did not start conversion");
endmodule

// ---- sacc_analog_model.sv ----
`timescale 1ns/1ns
// Behavioural front end: picks the level for the selected input and compares it with the DAC code.
module sacc_analog_model
	import sacc_pkg::*;
#(
	parameter logic [9:0] TEMP_LEVEL = 10'h2a9, // arbitrary sensor reading
	parameter logic [9:0] BGAP_LEVEL = 10'h174  // arbitrary bandgap reading
)
(
	input  wire logic         core_clk,            // system clock
	input  wire sacc_analog_t analogIn,            // front end control
	input  wire logic [9:0]   pinLevel,            // level on the selected pin
	input  wire logic         bandgapBufferEnable, // bandgap buffer on
	output logic              comparatorHigh       // input at or above DAC code
);
	logic [9:0] level;
	logic       noise = 1'b0;

	// Undriven inputs must not look like a stable level, so they toggle every cycle.
	always @(posedge core_clk)
	begin
		noise <= ~noise;
	end

	always_comb
	begin
		case (analogIn.muxSelect)
			5'h00, 5'h01, 5'h02, 5'h03, 5'h08, 5'h09, 5'h0a, 5'h0b: level = pinLevel;
			5'h1a: level = TEMP_LEVEL;
			5'h1b: level = bandgapBufferEnable ? BGAP_LEVEL : {10{noise}};
			5'h1d: level = 10'h3ff;
			5'h16, 5'h17, 5'h18, 5'h19, 5'h1c: level = {10{noise}};
			default: level = 10'h000;
		endcase
		comparatorHigh = analogIn.powerUp ? (level >= analogIn.dacCode) : noise;
	end
endmodule

// ---- tb.sv ----
`timescale 1ns/1ns
module tb;
	import sacc_pkg::*;
	localparam logic [9:0] TEMP_LV = 10'h2a9;
	localparam logic [9:0] BG_LV = 10'h174;
	localparam logic [4:0] PIN_CH [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h08, 5'h09, 5'h0a, 5'h0b};
	localparam logic [4:0] UNI_CH [6] = '{5'h04, 5'h07, 5'h0c, 5'h0f, 5'h10, 5'h15};
	localparam logic [4:0] RSV_CH [5] = '{5'h16, 5'h17, 5'h18, 5'h19, 5'h1c};
	logic         core_clk = 1'b0;
	logic         sys_rst = 1'b1;
	logic         clkEn = 1'b1;
	sacc_ctrl_t   ctrlIn = '0;
	logic         ctrlWrite = 1'b0;
	logic [9:0]   compareValue = 10'h200;
	logic         resultLowRead = 1'b0;
	logic [15:0]  pinEnableIn = 16'h0;
	logic         pinEnableWrite = 1'b0;
	logic         localAsyncTick = 1'b0;
	logic         altClockTick = 1'b0;
	logic         refClockTick = 1'b0;
	logic         rtiUseRef = 1'b0;
	logic [3:0]   periodicRateSelect = 4'h0;
	logic         comparatorHigh;
	sacc_analog_t analogOut;
	logic [9:0]   result;
	logic         conversionComplete;
	logic         completeIrq;
	logic         busy;
	logic [15:0]  pinEnable;
	sacc_kind_t   inputKind;
	logic [9:0]   pinLevel = 10'h0;
	logic         bgOn = 1'b0;
	logic         flagPrev = 1'b0;
	logic [31:0]  seedT = 32'hf528362b;
	logic [31:0]  seedM = 32'hf528362b;
	logic [9:0]   noteQ [$];
	int           fail_count = 0;
	int           comparisons = 0;
	int           n;
	sacc_ctrl_t   c;

	sacc_ctrl #(.RTI_W(16), .LPO_CYC(10)) u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn),
		.ctrlIn(ctrlIn), .ctrlWrite(ctrlWrite), .compareValue(compareValue), .resultLowRead(resultLowRead),
		.pinEnableIn(pinEnableIn), .pinEnableWrite(pinEnableWrite), .localAsyncTick(localAsyncTick),
		.altClockTick(altClockTick), .refClockTick(refClockTick), .rtiUseRef(rtiUseRef),
		.periodicRateSelect(periodicRateSelect), .comparatorHigh(comparatorHigh), .analogOut(analogOut),
		.result(result), .conversionComplete(conversionComplete), .completeIrq(completeIrq), .busy(busy),
		.pinEnable(pinEnable), .inputKind(inputKind));
	sacc_analog_model #(.TEMP_LEVEL(TEMP_LV), .BGAP_LEVEL(BG_LV)) u_front (.core_clk(core_clk),
		.analogIn(analogOut), .pinLevel(pinLevel), .bandgapBufferEnable(bgOn), .comparatorHigh(comparatorHigh));

	always #10 core_clk = ~core_clk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// The slow sources tick at random so divider phase never lines up with the write.
	always @(negedge core_clk)
	begin
		seedT = lfsr(seedT);
		localAsyncTick <= seedT[0];
		altClockTick <= seedT[1];
		refClockTick <= seedT[2] & seedT[3];
	end

	task automatic check_val(input string nm, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e)
		begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask

	// Each new completion takes the oldest expected result.
	always @(negedge core_clk)
	begin
		if (conversionComplete === 1'b1 && flagPrev !== 1'b1)
		begin
			if (noteQ.size() == 0)
				check_val("unexpected_done", 16'h0, 16'h1);
			else
				check_val("result", 16'(noteQ.pop_front()), 16'(result));
		end
		flagPrev <= conversionComplete;
	end

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	task automatic wr(input sacc_ctrl_t v);
		@(negedge core_clk);
		ctrlIn = v;
		ctrlWrite = 1'b1;
		@(negedge core_clk);
		ctrlWrite = 1'b0;
	endtask

	task automatic wait_idle(input logic hw);
		n = 0;
		while ((busy !== 1'b0 || (hw && conversionComplete !== 1'b1)) && n < 3000)
		begin
			@(negedge core_clk);
			n++;
		end
		check_val("idle", 16'h0, 16'(busy));
	endtask

	task automatic run(input sacc_ctrl_t v, input logic [9:0] vin, input logic [9:0] ev, input logic ef);
		pinLevel = vin;
		if (ef)
			noteQ.push_back(ev);
		wr(v);
		wait_idle(v.hwTrigEnable);
		repeat (2) @(negedge core_clk);
		check_val("flag", 16'(ef), 16'(conversionComplete));
		check_val("irq", 16'(ef & v.completeIntEnable), 16'(completeIrq));
	endtask

	initial
	begin
		#1500000;
		fail_count++;
		finish_test();
	end

	initial
	begin
		repeat (3) @(negedge core_clk);
		sys_rst = 1'b0;
		check_val("busy", 16'h0, 16'(busy));
		check_val("pins", 16'h0, pinEnable);
		check_val("power", 16'h0, 16'(analogOut.powerUp));
		done("reset");
		foreach (PIN_CH[i])
		begin
			seedM = lfsr(seedM);
			c = '0;
			c.channelSelect = PIN_CH[i];
			run(c, seedM[9:0], seedM[9:0], 1'b1);
			check_val("kind", 16'(IN_PIN), 16'(inputKind));
			c.mode8 = 1'b1;
			run(c, seedM[9:0], {2'b00, seedM[9:2]}, 1'b1);
		end
		foreach (UNI_CH[i])
		begin
			c = '0;
			c.channelSelect = UNI_CH[i];
			run(c, 10'h3ff, 10'h000, 1'b1);
			check_val("kind", 16'(IN_VREFL), 16'(inputKind));
		end
		done("channels");
		c = '0;
		c.channelSelect = 5'h1a;
		run(c, 10'h0, TEMP_LV, 1'b1);
		check_val("kind", 16'(IN_INTERNAL), 16'(inputKind));
		bgOn = 1'b1;
		c.channelSelect = 5'h1b;
		run(c, 10'h0, BG_LV, 1'b1);
		c.channelSelect = 5'h1e;
		run(c, 10'h3ff, 10'h000, 1'b1);
		foreach (RSV_CH[i])
		begin
			c.channelSelect = RSV_CH[i];
			wr(c);
			check_val("kind", 16'(IN_RESERVED), 16'(inputKind));
		end
		done("internal");
		for (int s = 0; s < 5; s++)
		begin
			c = '0;
			c.channelSelect = 5'h1d;
			c.clkSource = sacc_src_t'(s % 4);
			c.clockDivideSelect = 2'(s);
			c.longSample = (s == 4);
			run(c, 10'h0, 10'h3ff, 1'b1);
			if (s < 2)
				check_val("cycles", 16'h1, 16'(n >= (12 << (s + s)) - s && n <= (14 << (s + s)) + 4));
			if (s == 4)
				check_val("cycles", 16'h1, 16'(n >= 18 && n <= 20 + 4));
		end
		c = '0;
		c.channelSelect = 5'h1d;
		c.lowPower = 1'b1;
		run(c, 10'h0, 10'h3ff, 1'b1);
		check_val("bias", 16'h1, 16'(analogOut.compHigh));
		done("clocks");
		c = '0;
		c.compareEnable = 1'b1;
		run(c, 10'h1ff, 10'h1ff, 1'b1);
		run(c, 10'h200, 10'h000, 1'b0);
		c.compareGreater = 1'b1;
		run(c, 10'h200, 10'h200, 1'b1);
		run(c, 10'h1ff, 10'h000, 1'b0);
		c = '0;
		c.completeIntEnable = 1'b1;
		run(c, 10'h0aa, 10'h0aa, 1'b1);
		resultLowRead = 1'b1;
		@(negedge core_clk);
		resultLowRead = 1'b0;
		check_val("flag", 16'h0, 16'(conversionComplete));
		check_val("irq", 16'h0, 16'(completeIrq));
		done("compare");
		c = '0;
		wr(c);
		c.channelSelect = 5'h1d;
		run(c, 10'h155, 10'h3ff, 1'b1);
		c.continuous = 1'b1;
		c.channelSelect = 5'h00;
		noteQ.push_back(10'h111);
		pinLevel = 10'h111;
		wr(c);
		repeat (40) @(negedge core_clk);
		pinLevel = 10'h2ee;
		repeat (40) @(negedge core_clk);
		check_val("result", 16'h2ee, 16'(result));
		c.channelSelect = 5'h1f;
		wr(c);
		repeat (20) @(negedge core_clk);
		check_val("busy", 16'h0, 16'(busy));
		check_val("flag", 16'h0, 16'(conversionComplete));
		check_val("power", 16'h0, 16'(analogOut.powerUp));
		done("abort");
		c = '0;
		c.hwTrigEnable = 1'b1;
		for (int r = 0; r < 2; r++)
		begin
			rtiUseRef = r[0];
			periodicRateSelect = 4'(r);
			run(c, 10'h2aa, 10'h2aa, 1'b1);
			if (r == 0)
				check_val("trig_cycles", 16'h1, 16'(n >= 12 && n <= 36));
		end
		c = '0;
		c.channelSelect = 5'h1f;
		wr(c);
		c.channelSelect = 5'h1d;
		noteQ.push_back(10'h3ff);
		wr(c);
		clkEn = 1'b0;
		repeat (40) @(negedge core_clk);
		check_val("frozen", 16'h5, {13'h0, busy, conversionComplete, analogOut.sampleHold});
		clkEn = 1'b1;
		wait_idle(1'b0);
		done("trigger");
		seedM = lfsr(seedM);
		pinEnableIn = seedM[15:0];
		pinEnableWrite = 1'b1;
		@(negedge core_clk);
		pinEnableWrite = 1'b0;
		check_val("pins", seedM[15:0], pinEnable);
		repeat (4) @(negedge core_clk);
		check_val("notes_left", 16'h0, 16'(noteQ.size()));
		done("pins");
		finish_test();
	end
endmodule
